/* File: rtl/phs_header_coder.sv */
// Header builder, shortened RS coder, header splitter and payload scrambler with APB registers
//
// The implementer's own choices: the placing of the registers and the APB register port.

// Notes on behaviour
// - Transmit power code sits in header bits 37 to 39.
// - Power code maps linearly, 3 dB per step, 0 to 21 dB.
// - Header bits 30, 31 and 34 to 36 are reserved.
// - Reserved header bits are driven to zero.
// - MAC header is copied into the header unaltered.
// - Headers go through a systematic (23,15,4) RS coder, 184-bit result.
// - Tail bits at middle and end give 196 bits, split in two halves of 98.
// - Each half is then convolutionally coded, interleaved and QPSK mapped downstream.
// - Halves become first then second header symbol, each with 1/8 prefix.
// - Zero octets prefix the message, mother (255,245,5) code encodes it.
// - Surplus trailing parity and the padding are dropped, leaving (23,15,4).
// - Header valid flag clears on unrecoverable header, sets otherwise.
// - Payload scrambled by 9-stage PRBS, polynomial x^9 + x^4 + 1.
// - Scrambler reloads each payload unit from the two header seed bits.
// - Seed bits occupy header bits 28 and 29.
// - Sequence repeats every 511 bits; same logic descrambles.
// - Output matches reference sequences for each seed value.
module phs_header_coder
  import phs_pkg::*;
  #(
    parameter logic [8:0] SEED_INIT_00 = 9'h1BC,
    parameter logic [8:0] SEED_INIT_01 = 9'h034,
    parameter logic [8:0] SEED_INIT_10 = 9'h0F0,
    parameter logic [8:0] SEED_INIT_11 = 9'h0CE
  )
  (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    output logic                 irq,
    input  wire logic            hdr_req_valid,
    input  wire phs_hdr_req_type hdr_req,
    output logic                 hdr_busy,
    output logic                 hdr_out_valid,
    output logic      [97:0]     first_header_symbol,
    output logic      [97:0]     second_header_symbol,
    output logic      [4:0]      relative_power_db,
    input  wire logic            rx_rs_done,
    input  wire logic            rx_rs_fail,
    output logic                 header_valid_flag,
    input  wire phs_bit_type     pay_in,
    output phs_bit_type          pay_out
  );

  // Encoder states
  typedef enum logic [2:0] {
    PHS_ST_IDLE = 3'b001,
    PHS_ST_ENC  = 3'b010,
    PHS_ST_OUT  = 3'b100
  } phs_state_type;

  // Initial shift register contents for a seed; bit 0 is the next output
  function automatic logic [8:0] phs_seed_init(input logic [1:0] seed);
    logic [8:0] v;
    unique case (seed)
      2'h0: v = SEED_INIT_00;
      2'h1: v = SEED_INIT_01;
      2'h2: v = SEED_INIT_10;
      2'h3: v = SEED_INIT_11;
    endcase
    return v;
  endfunction

  // Advance the PRBS by one bit
  function automatic logic [8:0] phs_prbs_step(input logic [8:0] s);
    return {s[PHS_PRBS_TAP] ^ s[0], s[8:1]};
  endfunction

  phs_state_type         state_r;
  logic [119:0]          msg_r;
  logic [119:0]          feed_r;
  logic [3:0]            byte_cnt_r;
  logic [7:0]            par_r [0:9];
  logic [7:0]            par_nxt [0:9];
  logic [7:0]            fb;
  logic [1:0]            seed_r;
  logic [2:0]            power_r;
  logic [8:0]            prbs_r;
  logic [8:0]            prbs_cur;
  logic [1:0]            ctrl_r;
  logic [2:0]            status_r;
  logic [2:0]            mask_r;
  logic [2:0]            ev_set;
  logic [183:0]          vec;
  logic [39:0]           phy_hdr;
  logic                  take;
  logic                  apb_acc;
  logic                  apb_wr;
  logic                  apb_rd;
  logic                  status_rd;
  logic [31:0]           rd_mux;
  logic                  rd_hit;

  assign take    = hdr_req_valid & (state_r == PHS_ST_IDLE);
  assign apb_acc = psel & penable & ~pready;
  assign apb_wr  = psel & penable & pready & pwrite; // Write lands on the answer edge
  assign apb_rd  = apb_acc & ~pwrite;

  // Build the PHY header; low fields cover rate, mode, length and prefix bits
  always_comb
  begin
    phy_hdr = '0;
    phy_hdr[27:0] = hdr_req.low_fields;
    phy_hdr[PHS_SEED_POS +: 2] = hdr_req.seed;
    phy_hdr[PHS_INTLV_POS +: 2] = hdr_req.intlvr;
    phy_hdr[PHS_POWER_POS +: 3] = hdr_req.power;
    // reserved positions 30, 31 and 34 to 36
    phy_hdr[31:30] = 2'h0;
    phy_hdr[36:34] = 3'h0;
  end

  // Encoder sequencing and request capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r    <= PHS_ST_IDLE;
      msg_r      <= '0;
      feed_r     <= '0;
      byte_cnt_r <= 4'h0;
      seed_r     <= 2'h0;
      power_r    <= 3'h0;
    end
    else
    begin
      unique case (state_r)
        PHS_ST_IDLE:
        begin
          if (take)
          begin
            msg_r      <= {hdr_req.mac_hdr, phy_hdr};
            feed_r     <= {hdr_req.mac_hdr, phy_hdr};
            seed_r     <= hdr_req.seed;
            power_r    <= hdr_req.power;
            byte_cnt_r <= 4'h0;
            state_r    <= PHS_ST_ENC;
          end
        end
        PHS_ST_ENC:
        begin
          feed_r     <= {8'h00, feed_r[119:8]};
          byte_cnt_r <= byte_cnt_r + 4'h1;
          if (byte_cnt_r == PHS_BYTE_LAST)
            state_r <= PHS_ST_OUT;
        end
        PHS_ST_OUT:
          state_r <= PHS_ST_IDLE;
      endcase
    end
  end

  // zero prefix leaves the register zero, so only real octets are fed
  // systematic division by the mother generator, one octet a cycle
  always_comb
  begin
    fb = feed_r[7:0] ^ par_r[PHS_PAR_MOTHER-1];
    par_nxt[0] = phs_gf_mul(fb, PHS_RS_GEN[7:0]);
    for (int j = 1; j < PHS_PAR_MOTHER; j++)
      par_nxt[j] = par_r[j-1] ^ phs_gf_mul(fb, PHS_RS_GEN[8*j +: 8]);
  end

  // Parity registers, cleared at each new header
  generate
    for (genvar j = 0; j < PHS_PAR_MOTHER; j++)
    begin : g_par
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          par_r[j] <= 8'h00;
        else if (take)
          par_r[j] <= 8'h00;
        else if (state_r == PHS_ST_ENC)
          par_r[j] <= par_nxt[j];
      end
    end
  endgenerate

  // keep the first 8 parity octets, drop the last 2 and the padding
  always_comb
  begin
    vec = '0;
    vec[PHS_MSG_W-1:0] = msg_r;
    for (int k = 0; k < PHS_PAR_KEEP; k++)
      vec[PHS_MSG_W + 8*k +: 8] = par_r[PHS_PAR_MOTHER-1-k];
  end

  // Header outputs and busy flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hdr_busy             <= 1'b0;
      hdr_out_valid        <= 1'b0;
      first_header_symbol  <= '0;
      second_header_symbol <= '0;
      relative_power_db    <= 5'h00;
    end
    else
    begin
      hdr_busy      <= take | (state_r == PHS_ST_ENC);
      hdr_out_valid <= (state_r == PHS_ST_OUT);
      if (state_r == PHS_ST_OUT)
      begin
        // tail bits after each 92-bit half
        first_header_symbol  <= {{PHS_TAIL_W{1'b0}}, vec[PHS_HALF_DATA-1:0]};
        second_header_symbol <= {{PHS_TAIL_W{1'b0}}, vec[PHS_VEC_W-1:PHS_HALF_DATA]};
        // symbols handed to the inner coder
        relative_power_db    <= 5'(power_r * PHS_DB_STEP);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      header_valid_flag <= 1'b0;
    else if (rx_rs_done)
      header_valid_flag <= ~rx_rs_fail;
  end

  // reload at unit start from the header seed
  // initial state per seed gives the reference sequence
  assign prbs_cur = pay_in.start ? phs_seed_init(seed_r) : prbs_r;

  // x^9 + x^4 + 1 shift register
  // maximal length gives a 511-bit period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prbs_r <= 9'h000;
    else if (pay_in.valid)
      prbs_r <= phs_prbs_step(prbs_cur);
  end

  // payload bit XOR PRBS bit; same path descrambles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pay_out <= '0;
    else
    begin
      pay_out.valid <= pay_in.valid;
      pay_out.start <= pay_in.start & pay_in.valid;
      pay_out.data  <= pay_in.data ^ (prbs_cur[0] & ctrl_r[PHS_CTRL_SCR_EN]);
    end
  end

  // Events that set sticky status bits
  assign ev_set[PHS_EV_HDR_DONE] = (state_r == PHS_ST_OUT);
  assign ev_set[PHS_EV_HDR_BAD]  = rx_rs_done & rx_rs_fail;
  assign ev_set[PHS_EV_UNIT]     = pay_in.valid & pay_in.start;
  assign status_rd = apb_rd & (paddr == PHS_STATUS_OFS);

  // Status: a read clears, a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_r <= 3'h0;
    else
      status_r <= (status_rd ? 3'h0 : status_r) | ev_set;
  end

  // Control and mask registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= PHS_CTRL_RST;
      mask_r <= PHS_MASK_RST;
    end
    else if (apb_wr)
    begin
      if (paddr == PHS_CTRL_OFS)
        ctrl_r <= pwdata[1:0];
      if (paddr == PHS_MASK_OFS)
        mask_r <= pwdata[PHS_EV_W-1:0];
    end
  end

  // Interrupt level from unmasked status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(((status_rd ? 3'h0 : status_r) | ev_set) & mask_r);
  end

  // Read data selection
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr)
      PHS_CTRL_OFS:   rd_mux[1:0] = ctrl_r;
      PHS_STATUS_OFS: rd_mux[2:0] = status_r;
      PHS_MASK_OFS:   rd_mux[2:0] = mask_r;
      PHS_INFO_OFS:   rd_mux[11:0] = {relative_power_db, hdr_busy, header_valid_flag,
                                      seed_r, power_r};
      PHS_SCR_OFS:    rd_mux[8:0] = prbs_r;
      default:        rd_hit = 1'b0;
    endcase
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= apb_acc;
      pslverr <= apb_acc & ~rd_hit;
      prdata  <= apb_rd ? rd_mux : 32'h0000_0000;
    end
  end

endmodule : phs_header_coder

/* File: rtl/phs_pkg.sv */
// Package: constants, carrier types and helper functions of the header coder and scrambler
package phs_pkg;

  // APB register byte offsets
  localparam logic [11:0] PHS_CTRL_OFS     = 12'h000;
  localparam logic [11:0] PHS_STATUS_OFS   = 12'h004;
  localparam logic [11:0] PHS_MASK_OFS     = 12'h008;
  localparam logic [11:0] PHS_INFO_OFS     = 12'h00C;
  localparam logic [11:0] PHS_SCR_OFS      = 12'h010;

  // Reset values
  localparam logic [1:0]  PHS_CTRL_RST     = 2'h1;
  localparam logic [2:0]  PHS_MASK_RST     = 3'h0;

  // Status and mask bit positions
  localparam int          PHS_EV_HDR_DONE  = 0;
  localparam int          PHS_EV_HDR_BAD   = 1;
  localparam int          PHS_EV_UNIT      = 2;
  localparam int          PHS_EV_W         = 3;

  // Control bit positions
  localparam int          PHS_CTRL_SCR_EN  = 0;
  localparam int          PHS_CTRL_BYPASS  = 1;

  // Header layout
  localparam int          PHS_PHY_W        = 40;
  localparam int          PHS_MAC_W        = 80;
  localparam int          PHS_MSG_W        = 120;
  localparam int          PHS_MSG_BYTES    = 15;
  localparam int          PHS_PAR_KEEP     = 8;
  localparam int          PHS_PAR_MOTHER   = 10;
  localparam int          PHS_VEC_W        = 184;
  localparam int          PHS_HALF_DATA    = 92;
  localparam int          PHS_TAIL_W       = 6;
  localparam int          PHS_SYM_W        = 98;
  localparam int          PHS_SEED_POS     = 28;
  localparam int          PHS_INTLV_POS    = 32;
  localparam int          PHS_POWER_POS    = 37;
  localparam logic [3:0]  PHS_BYTE_LAST    = 4'hE;
  localparam logic [4:0]  PHS_DB_STEP      = 5'h3;

  // Reed-Solomon field and generator
  localparam logic [7:0]  PHS_GF_POLY      = 8'h1D;
  localparam int          PHS_RS_FCR       = 0;

  // Scrambler
  localparam int          PHS_PRBS_W       = 9;
  localparam int          PHS_PRBS_TAP     = 5;

  // Header request from the MAC side
  typedef struct packed {
    logic [79:0] mac_hdr;
    logic [2:0]  power;
    logic [1:0]  intlvr;
    logic [1:0]  seed;
    logic [27:0] low_fields;
  } phs_hdr_req_type;

  // One serial payload bit
  typedef struct packed {
    logic valid;
    logic start;
    logic data;
  } phs_bit_type;

  // Multiply by x in GF(256)
  function automatic logic [7:0] phs_xtime(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? PHS_GF_POLY : 8'h00);
  endfunction

  // GF(256) multiply
  function automatic logic [7:0] phs_gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] acc;
    logic [7:0] sh;
    acc = 8'h00;
    sh  = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
        acc = acc ^ sh;
      sh = phs_xtime(sh);
    end
    return acc;
  endfunction

  // Mother generator polynomial, coefficients 0..9, leading one implied
  function automatic logic [79:0] phs_gen_poly();
    logic [7:0] g [0:10];
    logic [7:0] root;
    logic [79:0] res;
    for (int j = 0; j <= 10; j++)
      g[j] = 8'h00;
    g[0] = 8'h01;
    root = 8'h01;
    for (int k = 0; k < PHS_RS_FCR; k++)
      root = phs_xtime(root);
    for (int i = 0; i < PHS_PAR_MOTHER; i++)
    begin
      for (int j = 10; j > 0; j--)
        g[j] = g[j-1] ^ phs_gf_mul(g[j], root);
      g[0] = phs_gf_mul(g[0], root);
      root = phs_xtime(root);
    end
    for (int j = 0; j < PHS_PAR_MOTHER; j++)
      res[8*j +: 8] = g[j];
    return res;
  endfunction

  localparam logic [79:0] PHS_RS_GEN = phs_gen_poly();

endpackage : phs_pkg

/* File: tb/phs_header_coder_props.sv */
// Checker: port-level assertions for the header coder and scrambler
module phs_header_coder_props
  import phs_pkg::*;
  (
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            hdr_req_valid,
    input wire phs_hdr_req_type hdr_req,
    input wire logic            hdr_busy,
    input wire logic            hdr_out_valid,
    input wire logic [97:0]     first_header_symbol,
    input wire logic [97:0]     second_header_symbol,
    input wire logic [4:0]      relative_power_db,
    input wire logic            rx_rs_done,
    input wire logic            rx_rs_fail,
    input wire logic            header_valid_flag,
    input wire phs_bit_type     pay_in,
    input wire phs_bit_type     pay_out
  );
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // APB access still waiting for its answer
  sequence s_access;
    psel && penable && !pready;
  endsequence

  // Header request taken by an idle encoder
  sequence s_take;
    hdr_req_valid && !hdr_busy;
  endsequence

  // Result of a taken header, 17 cycles on
  property p_power;
    logic [2:0] c;
    (s_take, c = hdr_req.power) |-> ##17 (hdr_out_valid
      && first_header_symbol[39:37] == c && relative_power_db == 5'(3 * c));
  endproperty

  property p_mac;
    logic [79:0] m;
    (s_take, m = hdr_req.mac_hdr) |-> ##17
      ({second_header_symbol[27:0], first_header_symbol[91:40]} == m);
  endproperty

  property p_seed;
    logic [1:0] s;
    (s_take, s = hdr_req.seed) |-> ##17 (first_header_symbol[29:28] == s);
  endproperty

  a_wait_state: assert property (s_access |=> pready)
    else $error("late APB answer");
  a_read_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_power_field: assert property (p_power)
    else $error("power field or dB value wrong");
  a_mac_copy: assert property (p_mac)
    else $error("MAC header altered");
  a_seed_field: assert property (p_seed)
    else $error("seed bits misplaced");
  a_reserved_zero: assert property (hdr_out_valid |-> first_header_symbol[31:30] == 2'h0
    && first_header_symbol[36:34] == 3'h0)
    else $error("reserved bits not zero");
  a_tail_zero: assert property (hdr_out_valid |-> first_header_symbol[97:92] == 6'h0
    && second_header_symbol[97:92] == 6'h0)
    else $error("tail bits not zero");
  a_symbol_hold: assert property (!hdr_out_valid |-> $stable(first_header_symbol)
    && $stable(second_header_symbol))
    else $error("symbols changed between headers");
  a_pay_delay: assert property (pay_in.valid |=> pay_out.valid
    && pay_out.start == $past(pay_in.start))
    else $error("payload bit not passed after one cycle");
  a_flag_update: assert property (rx_rs_done |=> header_valid_flag == !$past(rx_rs_fail))
    else $error("valid flag wrong after decode");
endmodule // phs_header_coder_props

bind phs_header_coder phs_header_coder_props u_props (
  .pclk, .presetn, .psel, .penable, .prdata, .pready, .hdr_req_valid, .hdr_req,
  .hdr_busy, .hdr_out_valid, .first_header_symbol, .second_header_symbol,
  .relative_power_db, .rx_rs_done, .rx_rs_fail, .header_valid_flag, .pay_in, .pay_out);

/* File: tb/phs_mac_model.sv */
// Partner model: upstream MAC side feeding headers and payload bits
module phs_mac_model
  import phs_pkg::*;
  (
    input  wire logic            pclk,
    input  wire logic            hdr_busy,
    output logic                 hdr_req_valid,
    output phs_hdr_req_type      hdr_req,
    output phs_bit_type          pay_in
  );
  timeunit 1ns;
  timeprecision 1ns;

  // Quiet lines at time zero
  initial
  begin
    hdr_req_valid = 1'b0;
    hdr_req       = '0;
    pay_in        = '0;
  end

  // Offer a header until an idle edge takes it, then scramble the stale fields
  task automatic send_hdr(input phs_hdr_req_type h);
    hdr_req_valid <= 1'b1;
    hdr_req       <= h;
    do
      @(posedge pclk);
    while (hdr_busy);
    hdr_req_valid <= 1'b0;
    hdr_req       <= ~h;
  endtask

  task automatic put(input logic v, input logic s, input logic d);
    pay_in <= '{valid: v, start: s, data: d};
    @(posedge pclk);
  endtask
endmodule // phs_mac_model

/* File: tb/phs_header_coder_bench.sv */
// Testbench: drives APB, headers and payload, checks results from queues
module phs_header_coder_bench
  import phs_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;

  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata;
  logic            hdr_req_valid, hdr_busy, hdr_out_valid;
  logic [97:0]     first_header_symbol, second_header_symbol;
  logic [4:0]      relative_power_db;
  logic            rx_rs_done, rx_rs_fail, header_valid_flag;
  phs_hdr_req_type hdr_req;
  phs_bit_type     pay_in, pay_out;
  logic [32:0]     q_rd[$];
  logic [200:0]    q_hdr[$];
  logic [1:0]      q_pay[$];
  logic [31:0]     x = 32'h1;
  logic [7:0]      g[0:10];
  logic [7:0]      rt;
  int              n_fail = 0;
  int              num_checks = 0;

  phs_header_coder dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .hdr_req_valid, .hdr_req, .hdr_busy, .hdr_out_valid,
    .first_header_symbol, .second_header_symbol, .relative_power_db, .rx_rs_done,
    .rx_rs_fail, .header_valid_flag, .pay_in, .pay_out);
  phs_mac_model mac (.pclk, .hdr_busy, .hdr_req_valid, .hdr_req, .pay_in);

  // Clock
  always #5 pclk = ~pclk;

  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // Field multiply with x^8+x^4+x^3+x^2+1
  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
        p = p ^ a;
      a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1D : 8'h00);
    end
    return p;
  endfunction

  task automatic chk(input logic [200:0] got, input logic [200:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    q_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // Header with reference RS parity and expected symbols
  task automatic hdr(input logic [2:0] pw, input logic [1:0] sd);
    phs_hdr_req_type h;
    logic [127:0]    t;
    logic [119:0]    m;
    logic [183:0]    v;
    logic [7:0]      r[0:9];
    logic [7:0]      fb;
    t = {rnd(), rnd(), rnd(), rnd()};
    h = t[114:0];
    h.power = pw;
    h.seed = sd;
    m = {h.mac_hdr, pw, 3'h0, h.intlvr, 2'h0, sd, h.low_fields};
    r = '{default: 8'h00};
    for (int i = 0; i < 15; i++)
    begin
      fb = m[8*i +: 8] ^ r[9];
      for (int j = 9; j > 0; j--)
        r[j] = r[j-1] ^ gm(fb, g[j]);
      r[0] = gm(fb, g[0]);
    end
    v[119:0] = m;
    for (int k = 0; k < 8; k++)
      v[120 + 8*k +: 8] = r[9-k];
    q_hdr.push_back({5'(3 * pw), 6'h0, v[183:92], 6'h0, v[91:0]});
    mac.send_hdr(h);
    repeat (20) @(posedge pclk);
  endtask

  // Payload unit; window starts as the first nine reference bits of the seed
  task automatic unit(input int n, input logic sd, input logic en);
    logic [8:0] w;
    logic       d;
    w = sd ? 9'h034 : 9'h1BC;
    for (int i = 0; i < n; i++)
    begin
      d = 1'(rnd() & 32'h1);
      q_pay.push_back({i == 0, d ^ (en & w[0])});
      mac.put(1'b1, i == 0, d);
      w = {w[0] ^ w[5], w[8:1]};
    end
    mac.put(1'b0, 1'b0, ~d);
  endtask

  task automatic rx(input logic f);
    @(posedge pclk);
    rx_rs_fail <= f;
    rx_rs_done <= 1'b1;
    @(posedge pclk);
    rx_rs_done <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(header_valid_flag, !f);
  endtask

  // Compare each result with the oldest note of its kind
  always @(posedge pclk)
  begin
    if (pready && !pwrite)
      chk({pslverr, prdata}, q_rd.pop_front());
    if (hdr_out_valid)
      chk({relative_power_db, second_header_symbol, first_header_symbol}, q_hdr.pop_front());
    if (pay_out.valid)
      chk({pay_out.start, pay_out.data}, q_pay.pop_front());
  end

  // Watchdog
  initial
  begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    close_out();
  end

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, rx_rs_done, rx_rs_fail} = '0;
    g = '{default: 8'h00};
    g[0] = 8'h01;
    rt = 8'h01;
    for (int i = 0; i < 10; i++)
    begin
      for (int j = 10; j > 0; j--)
        g[j] = g[j-1] ^ gm(g[j], rt);
      g[0] = gm(g[0], rt);
      rt = gm(rt, 8'h02);
    end
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(PHS_CTRL_OFS, 33'(PHS_CTRL_RST));
    rd(PHS_MASK_OFS, 33'h0);
    rd(PHS_STATUS_OFS, 33'h0);
    rd(12'h014, 33'h100000000);
    apb(1'b1, PHS_MASK_OFS, 32'h1);
    $display("registers done");
    for (int p = 0; p < 8; p++)
      hdr(p[2:0], 2'h0);
    chk(irq, 1'b1);
    rd(PHS_STATUS_OFS, 33'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    $display("headers done");
    unit(520, 1'b0, 1'b1);
    unit(12, 1'b0, 1'b1);
    chk(irq, 1'b0);
    rd(PHS_STATUS_OFS, 33'h4);
    hdr(3'h5, 2'h1);
    rd(PHS_INFO_OFS, 33'h78D);
    unit(30, 1'b1, 1'b1);
    apb(1'b1, PHS_CTRL_OFS, 32'h0);
    unit(10, 1'b1, 1'b0);
    apb(1'b1, PHS_CTRL_OFS, 32'h1);
    $display("payload done");
    rx(1'b0);
    rx(1'b1);
    rd(PHS_STATUS_OFS, 33'h7);
    $display("flag done");
    close_out();
  end
endmodule // phs_header_coder_bench
